// [verilog/sector_check_unit.sv]
// Purpose: sector check code unit with buffer address control and support latches
// Assumes: one 125 MHz clock; disk controller and processor share an 8-bit bus
// Notes: registers are reached over AHB-Lite; reads answer in one data cycle
//
// Our own choices: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ns
module sector_check_unit
#(
   parameter int addr_w = 16
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Disk controller byte link
   input wire logic disk_strobe,
   input wire logic [7:0] disk_rd_byte,
   output logic [7:0] disk_wr_byte,
   output logic disk_wr_valid,
   // Sector buffer
   output logic [addr_w-1:0] buf_addr,
   output logic buf_we,
   output logic [7:0] buf_wdata,
   input wire logic [7:0] buf_rdata,
   // Drive and head selects
   output logic [2:0] drive_sel,
   output logic [2:0] head_sel,
   // Status lines
   output logic data_req,
   output logic busy,
   output logic int_req
);
   logic rst_a_ff;
   logic rst_b_ff;
   logic rst_n;
   logic strb_a_ff;
   logic strb_b_ff;
   logic strb_c_ff;
   logic strb_lvl_ff;
   logic [7:0] rdb_a_ff;
   logic [7:0] rdb_b_ff;
   logic [7:0] rdb_c_ff;
   logic step;

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         rst_a_ff <= 1'b0;
         rst_b_ff <= 1'b0;
      end
      else
      begin
         rst_a_ff <= 1'b1;
         rst_b_ff <= rst_a_ff;
      end
   end
   assign rst_n = rst_b_ff;

   // Strobe from the disk controller crosses in with three stages
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         strb_a_ff <= 1'b0;
         strb_b_ff <= 1'b0;
         strb_c_ff <= 1'b0;
         strb_lvl_ff <= 1'b0;
         rdb_a_ff <= 8'h00;
         rdb_b_ff <= 8'h00;
         rdb_c_ff <= 8'h00;
      end
      else
      begin
         strb_a_ff <= disk_strobe;
         strb_b_ff <= strb_a_ff;
         strb_c_ff <= strb_b_ff;
         if (strb_b_ff == strb_c_ff)
            strb_lvl_ff <= strb_c_ff;
         rdb_a_ff <= disk_rd_byte;
         rdb_b_ff <= rdb_a_ff;
         rdb_c_ff <= rdb_b_ff;
      end
   end
   // A rise counts once the second and third stages agree, so the byte in the third stage belongs to it
   assign step = strb_b_ff & strb_c_ff & ~strb_lvl_ff;

   // Register and transfer state
   logic [7:0] cmd_ff, nxt_cmd;
   logic [7:0] sdh_ff, nxt_sdh;
   logic [7:0] ctrl_ff, nxt_ctrl;
   logic [1:0] size_ff, nxt_size;
   logic [addr_w-1:0] addr_ff, nxt_addr;
   logic [10:0] cnt_ff, nxt_cnt;
   logic [31:0] crc_ff, nxt_crc;
   logic [31:0] synd_ff, nxt_synd;
   logic [31:0] prev_synd_ff, nxt_prev_synd;
   logic [31:0] trail_ff, nxt_trail;
   logic [1:0] tidx_ff, nxt_tidx;
   logic [3:0] retry_ff, nxt_retry;
   logic match_ff, nxt_match;
   logic ovf_ff, nxt_ovf;
   logic drq_ff, nxt_drq;
   ecc_unit_pkg::xfer_e st_ff, nxt_st;
   logic busy_ff, nxt_busy;
   logic [7:0] wb_ff, nxt_wb;
   logic wv_ff, nxt_wv;
   logic bwe_ff, nxt_bwe;
   logic [7:0] bwd_ff, nxt_bwd;
   // AHB pipeline
   logic ap_ff, nxt_ap;
   logic apw_ff, nxt_apw;
   logic [7:0] apa_ff, nxt_apa;
   logic [31:0] rd_ff, nxt_rd;

   // Two bits of the generator per call
   function automatic logic [31:0] crc2(input logic [31:0] c, input logic [1:0] d);
      logic [31:0] r;
      logic fb;
      r = c;
      for (int i = 1; i >= 0; i--)
      begin
         fb = r[31] ^ d[i];
         r = {r[30:0], 1'b0} ^ (fb ? ecc_unit_pkg::poly : 32'h0000_0000);
      end
      return r;
   endfunction

   function automatic logic [31:0] crc8(input logic [31:0] c, input logic [7:0] d);
      logic [31:0] r;
      r = c;
      for (int k = 3; k >= 0; k--)
         r = crc2(r, d[2*k+:2]);
      return r;
   endfunction

   logic [10:0] sect_len;
   logic checking;
   logic dir_rd;
   logic long_m;
   logic [7:0] cur_byte;
   logic [31:0] crc_upd;
   logic bus_wr;
   logic bus_rd;
   logic [31:0] rd_val;

   always_comb
   begin
      sect_len = 11'h080 << size_ff;
      checking = sdh_ff[ecc_unit_pkg::sdh_enable_bit];
      dir_rd = ctrl_ff[ecc_unit_pkg::ctrl_dir_bit];
      long_m = ctrl_ff[ecc_unit_pkg::ctrl_long_bit];
      cur_byte = dir_rd ? rdb_c_ff : buf_rdata;
      crc_upd = crc8(crc_ff, cur_byte);
      bus_wr = ap_ff & apw_ff;
      bus_rd = hsel & hready & htrans[1] & ~hwrite;
   end

   always_comb
   begin
      rd_val = 32'h0000_0000;
      if (haddr[7:0] == ecc_unit_pkg::cmd_off)
         rd_val = {24'h0, cmd_ff};
      else if (haddr[7:0] == ecc_unit_pkg::sdh_off)
         rd_val = {24'h0, sdh_ff};
      else if (haddr[7:0] == ecc_unit_pkg::ctrl_off)
         rd_val = {22'h0, size_ff, ctrl_ff};
      else if (haddr[7:0] == ecc_unit_pkg::stat_off)
         rd_val = {24'h0, match_ff, ovf_ff, (synd_ff != 32'h0), drq_ff, (st_ff != ecc_unit_pkg::st_idle),
                   ctrl_ff[ecc_unit_pkg::ctrl_intrq_bit], ctrl_ff[ecc_unit_pkg::ctrl_multi_bit], dir_rd};
      else if (haddr[7:0] == ecc_unit_pkg::addr_off)
         rd_val = 32'(addr_ff);
      else if (haddr[7:0] == ecc_unit_pkg::data_off)
         rd_val = {24'h0, buf_rdata};
      else if (haddr[7:0] == ecc_unit_pkg::synd_off)
         rd_val = synd_ff;
      else if (haddr[7:0] == ecc_unit_pkg::retry_off)
         rd_val = {28'h0, retry_ff};
   end

   always_comb
   begin
      nxt_ap = hsel & hready & htrans[1];
      nxt_apw = hwrite;
      nxt_apa = haddr[7:0];
      nxt_rd = bus_rd ? rd_val : rd_ff;
      nxt_cmd = cmd_ff;
      nxt_sdh = sdh_ff;
      nxt_ctrl = ctrl_ff;
      nxt_size = size_ff;
      nxt_addr = addr_ff;
      nxt_cnt = cnt_ff;
      nxt_crc = crc_ff;
      nxt_synd = synd_ff;
      nxt_prev_synd = prev_synd_ff;
      nxt_trail = trail_ff;
      nxt_tidx = tidx_ff;
      nxt_retry = retry_ff;
      nxt_match = match_ff;
      nxt_ovf = ovf_ff;
      nxt_drq = drq_ff;
      nxt_st = st_ff;
      nxt_wb = wb_ff;
      nxt_wv = 1'b0;
      nxt_bwe = 1'b0;
      nxt_bwd = bwd_ff;
      // Register writes; most travel as bytes like the shared bus, but ctrl also takes the size from bits 9:8 and the trailer takes all 32 bits
      if (bus_wr)
      begin
         if (apa_ff == ecc_unit_pkg::cmd_off)
            nxt_cmd = hwdata[7:0];
         else if (apa_ff == ecc_unit_pkg::sdh_off)
            nxt_sdh = hwdata[7:0];
         else if (apa_ff == ecc_unit_pkg::ctrl_off)
         begin
            nxt_ctrl = hwdata[7:0];
            nxt_size = hwdata[9:8];
         end
         else if (apa_ff == ecc_unit_pkg::addr_off)
         begin
            if (hwdata[8])
               nxt_addr[addr_w-1:8] = hwdata[addr_w-9:0];
            else
               nxt_addr[7:0] = hwdata[7:0];
            nxt_ovf = 1'b0;
         end
         else if (apa_ff == ecc_unit_pkg::data_off)
         begin
            nxt_bwe = 1'b1;
            nxt_bwd = hwdata[7:0];
         end
         else if (apa_ff == ecc_unit_pkg::retry_off)
         begin
            nxt_trail = hwdata;
         end
      end
      case (st_ff)
         ecc_unit_pkg::st_idle:
         begin
            if (ctrl_ff[ecc_unit_pkg::ctrl_start_bit])
            begin
               nxt_ctrl[ecc_unit_pkg::ctrl_start_bit] = 1'b0;
               nxt_ctrl[ecc_unit_pkg::ctrl_intrq_bit] = 1'b0;
               nxt_crc = ecc_unit_pkg::crc_init;
               nxt_cnt = 11'h000;
               nxt_tidx = 2'h0;
               nxt_drq = 1'b1;
               nxt_st = ecc_unit_pkg::st_data;
            end
         end
         ecc_unit_pkg::st_data:
         begin
            if (step)
            begin
               if (checking)
                  nxt_crc = crc_upd;
               if (dir_rd)
               begin
                  nxt_bwe = 1'b1;
                  nxt_bwd = rdb_c_ff;
               end
               else
               begin
                  nxt_wb = buf_rdata;
                  nxt_wv = 1'b1;
                  nxt_addr = addr_ff + 1'b1;
                  if (&addr_ff)
                     nxt_ovf = 1'b1;
               end
               nxt_cnt = cnt_ff + 11'h001;
               if (cnt_ff + 11'h001 == sect_len)
                  nxt_st = (checking | long_m) ? ecc_unit_pkg::st_trailer : ecc_unit_pkg::st_done;
            end
         end
         ecc_unit_pkg::st_trailer:
         begin
            if (dir_rd ? step : 1'b1)
            begin
               if (!dir_rd)
               begin
                  nxt_wb = long_m ? trail_ff[31-8*tidx_ff-:8] : crc_ff[31-8*tidx_ff-:8];
                  nxt_wv = 1'b1;
               end
               else if (long_m)
               begin
                  nxt_trail[31-8*tidx_ff-:8] = rdb_c_ff;
                  nxt_bwe = 1'b1;
                  nxt_bwd = rdb_c_ff;
               end
               else
                  nxt_crc = crc_upd;
               nxt_tidx = tidx_ff + 2'h1;
               if (tidx_ff == ecc_unit_pkg::trailer_bytes)
                  nxt_st = ecc_unit_pkg::st_done;
            end
         end
         default:
         begin
            nxt_drq = 1'b0;
            nxt_ctrl[ecc_unit_pkg::ctrl_intrq_bit] = 1'b1;
            if (dir_rd && !long_m && checking)
            begin
               nxt_synd = crc_ff;
               nxt_match = (crc_ff == synd_ff);
               nxt_prev_synd = synd_ff;
               if (crc_ff != 32'h0 && crc_ff != synd_ff && retry_ff != ecc_unit_pkg::max_retries)
                  nxt_retry = retry_ff + 4'h1;
               if (crc_ff != 32'h0 && (retry_ff == ecc_unit_pkg::max_retries))
                  nxt_cmd = 8'h40;
               if (crc_ff == 32'h0)
                  nxt_retry = 4'h0;
            end
            nxt_st = ecc_unit_pkg::st_idle;
         end
      endcase
      // Counter advances after the buffer byte has landed; in disk writes it also steps with each byte read out
      if (bwe_ff)
      begin
         nxt_addr = addr_ff + 1'b1;
         if (&addr_ff)
            nxt_ovf = 1'b1;
      end
      nxt_busy = (nxt_st != ecc_unit_pkg::st_idle);
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ap_ff <= 1'b0;
         apw_ff <= 1'b0;
         apa_ff <= 8'h00;
         rd_ff <= 32'h0000_0000;
         cmd_ff <= 8'h00;
         sdh_ff <= 8'h00;
         ctrl_ff <= 8'h00;
         size_ff <= 2'h0;
         addr_ff <= '0;
         cnt_ff <= 11'h000;
         crc_ff <= ecc_unit_pkg::crc_init;
         synd_ff <= 32'h0000_0000;
         prev_synd_ff <= 32'h0000_0000;
         trail_ff <= 32'h0000_0000;
         tidx_ff <= 2'h0;
         retry_ff <= 4'h0;
         match_ff <= 1'b0;
         ovf_ff <= 1'b0;
         drq_ff <= 1'b0;
         st_ff <= ecc_unit_pkg::st_idle;
         wb_ff <= 8'h00;
         wv_ff <= 1'b0;
         bwe_ff <= 1'b0;
         bwd_ff <= 8'h00;
         busy_ff <= 1'b0;
      end
      else
      begin
         ap_ff <= nxt_ap;
         apw_ff <= nxt_apw;
         apa_ff <= nxt_apa;
         rd_ff <= nxt_rd;
         cmd_ff <= nxt_cmd;
         sdh_ff <= nxt_sdh;
         ctrl_ff <= nxt_ctrl;
         size_ff <= nxt_size;
         addr_ff <= nxt_addr;
         cnt_ff <= nxt_cnt;
         crc_ff <= nxt_crc;
         synd_ff <= nxt_synd;
         prev_synd_ff <= nxt_prev_synd;
         trail_ff <= nxt_trail;
         tidx_ff <= nxt_tidx;
         retry_ff <= nxt_retry;
         match_ff <= nxt_match;
         ovf_ff <= nxt_ovf;
         drq_ff <= nxt_drq;
         st_ff <= nxt_st;
         wb_ff <= nxt_wb;
         wv_ff <= nxt_wv;
         bwe_ff <= nxt_bwe;
         bwd_ff <= nxt_bwd;
         busy_ff <= nxt_busy;
      end
   end

   ecc_unit_pkg::select_s sel;
   assign sel = {sdh_ff[4:3], sdh_ff[2:0]};

   // Selects decoded from the head latch
   logic [2:0] drv_ff, nxt_drv;
   logic [2:0] hd_ff, nxt_hd;
   always_comb
   begin
      nxt_drv = 3'h0;
      if (sel.drive != 2'h0)
         nxt_drv = 3'h1 << (sel.drive - 2'h1);
      nxt_hd = sel.head;
   end
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         drv_ff <= 3'h0;
         hd_ff <= 3'h0;
      end
      else
      begin
         drv_ff <= nxt_drv;
         hd_ff <= nxt_hd;
      end
   end

   assign hrdata = rd_ff;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign disk_wr_byte = wb_ff;
   assign disk_wr_valid = wv_ff;
   assign buf_addr = addr_ff;
   assign buf_we = bwe_ff;
   assign buf_wdata = bwd_ff;
   assign drive_sel = drv_ff;
   assign head_sel = hd_ff;
   assign data_req = drq_ff;
   assign busy = busy_ff;
   assign int_req = ctrl_ff[ecc_unit_pkg::ctrl_intrq_bit];
endmodule // sector_check_unit

// [verilog/ecc_unit_pkg.sv]
// Purpose: constants and types for the disk sector check and buffer control unit
// Assumes: AHB-Lite register access, 125 MHz clock
package ecc_unit_pkg;
   localparam logic [7:0] cmd_off = 8'h00;
   localparam logic [7:0] sdh_off = 8'h04;
   localparam logic [7:0] ctrl_off = 8'h08;
   localparam logic [7:0] stat_off = 8'h0c;
   localparam logic [7:0] addr_off = 8'h10;
   localparam logic [7:0] data_off = 8'h14;
   localparam logic [7:0] synd_off = 8'h18;
   localparam logic [7:0] retry_off = 8'h1c;
   localparam logic [31:0] poly = 32'h0020_8003;
   localparam logic [31:0] crc_init = 32'h0000_0000;
   localparam int sdh_enable_bit = 7;
   localparam int ctrl_start_bit = 0;
   localparam int ctrl_dir_bit = 1;
   localparam int ctrl_long_bit = 2;
   localparam int ctrl_multi_bit = 3;
   localparam int ctrl_fix_bit = 4;
   localparam int ctrl_uncorr_bit = 5;
   localparam int ctrl_intrq_bit = 6;
   localparam logic [3:0] max_retries = 4'h8;
   localparam logic [1:0] trailer_bytes = 2'h3;
   typedef enum {st_idle, st_data, st_trailer, st_done} xfer_e;
   typedef struct packed
   {
      logic [1:0] drive;
      logic [2:0] head;
   } select_s;
endpackage

// [testbench/sector_check_unit_assertions.sv]
// Purpose: port checks for the sector check unit
// Assumes: one clock, reset_n active low
// Notes: bound to every instance of the unit
`timescale 1ns/1ns
module sector_check_unit_assertions
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Bus
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   input wire logic hreadyout,
   input wire logic hresp,
   // Unit outputs
   input wire logic disk_wr_valid,
   input wire logic [2:0] head_sel,
   input wire logic data_req,
   input wire logic busy,
   input wire logic int_req
);
   logic sdh_dp_ff;
   logic ctl_dp_ff;
   logic [31:0] sdh_val_ff;
   logic nxt_sdh_dp;
   logic nxt_ctl_dp;
   logic [31:0] nxt_sdh_val;
   logic wr_ap;
   assign wr_ap = hsel && hready && htrans[1] && hwrite;
   always_comb
   begin
      nxt_sdh_dp = wr_ap && haddr[7:0] == ecc_unit_pkg::sdh_off;
      nxt_ctl_dp = wr_ap && haddr[7:0] == ecc_unit_pkg::ctrl_off;
      nxt_sdh_val = sdh_dp_ff ? hwdata : sdh_val_ff;
   end
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         sdh_dp_ff <= 1'b0;
         ctl_dp_ff <= 1'b0;
         sdh_val_ff <= 32'h0;
      end
      else
      begin
         sdh_dp_ff <= nxt_sdh_dp;
         ctl_dp_ff <= nxt_ctl_dp;
         sdh_val_ff <= nxt_sdh_val;
      end
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);
   bus_okay_a: assert property (hreadyout && !hresp)
      else $error("bus answer not ready and okay");
   head_latch_a: assert property (sdh_dp_ff |=> ##[0:1] head_sel == sdh_val_ff[2:0])
      else $error("head select does not follow latch");
   start_busy_a: assert property (ctl_dp_ff && hwdata[0] |-> ##[1:3] busy)
      else $error("start did not raise busy");
   start_clear_a: assert property (ctl_dp_ff && hwdata[0] |-> ##[1:3] !int_req)
      else $error("start did not clear done");
   req_busy_a: assert property (data_req |-> busy)
      else $error("data request while not busy");
   done_quiet_a: assert property (int_req |-> !data_req)
      else $error("done with data request");
   trailer_len_a: assert property (disk_wr_valid [*5] |=> !disk_wr_valid)
      else $error("more than last byte and four check bytes in a burst");
   wr_in_xfer_a: assert property (disk_wr_valid |-> $past(busy))
      else $error("disk byte outside a transfer");
endmodule // sector_check_unit_assertions

bind sector_check_unit sector_check_unit_assertions chk (.clk(clk), .reset_n(reset_n), .hsel(hsel),
   .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata), .hreadyout(hreadyout),
   .hresp(hresp), .disk_wr_valid(disk_wr_valid), .head_sel(head_sel), .data_req(data_req), .busy(busy),
   .int_req(int_req));

// [testbench/disk_side_model.sv]
// Purpose: disk controller and sector buffer stand-in
// Assumes: the unit steps a byte after a synchronised strobe edge
// Notes: read byte turns to its inverse once the strobe drops
`timescale 1ns/1ns
module disk_side_model
(
   // Clock
   input wire logic clk,
   // Disk controller link
   output logic disk_strobe,
   output logic [7:0] disk_rd_byte,
   // Sector buffer
   input wire logic [15:0] buf_addr,
   input wire logic buf_we,
   input wire logic [7:0] buf_wdata,
   output logic [7:0] buf_rdata
);
   logic [7:0] mem [0:1023];
   logic [7:0] rd_q [$];
   assign buf_rdata = mem[buf_addr[9:0]];
   initial
   begin
      disk_strobe = 1'b0;
      disk_rd_byte = 8'h00;
      for (int i = 0; i < 1024; i++)
         mem[i] = 8'(i * 37 + 5);
   end
   always @(posedge clk)
   begin
      if (buf_we === 1'b1)
         mem[buf_addr[9:0]] <= buf_wdata;
   end
   // One strobe per byte; gap sets the pace
   task automatic frame(input int n, input int gap);
      logic [7:0] b;
      for (int i = 0; i < n; i++)
      begin
         b = (rd_q.size() > 0) ? rd_q.pop_front() : 8'(i);
         @(posedge clk);
         disk_rd_byte <= b;
         disk_strobe <= 1'b1;
         repeat (6) @(posedge clk);
         disk_strobe <= 1'b0;
         disk_rd_byte <= ~b;
         repeat (gap) @(posedge clk);
      end
   endtask
endmodule // disk_side_model

// [testbench/tb_disk_sector_ecc_and_buffer_control.sv]
// Purpose: self-checking bench for the sector check unit
// Assumes: single word bus transfers, disk side modelled
// Notes: stream results are matched against queued expectations
`timescale 1ns/1ns
module tb_disk_sector_ecc_and_buffer_control;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic hreadyout, hresp, disk_strobe, disk_wr_valid, buf_we, data_req, busy, int_req;
   logic [7:0] disk_rd_byte, disk_wr_byte, buf_wdata, buf_rdata, b;
   logic [15:0] buf_addr;
   logic [2:0] drive_sel, head_sel;
   int n_mismatch = 0;
   int n_checks = 0;
   int seed = 32'h3be1b471;
   logic [7:0] wr_q [$];
   logic [7:0] bw_q [$];
   logic [7:0] cap_q [$];
   logic [7:0] dat [0:127];
   logic [7:0] crc [0:3];
   logic [31:0] rd, s1;
   initial
   begin
      forever #4 clk = ~clk;
   end
   sector_check_unit #(.addr_w(16)) dut (.clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .disk_strobe(disk_strobe), .disk_rd_byte(disk_rd_byte),
      .disk_wr_byte(disk_wr_byte), .disk_wr_valid(disk_wr_valid), .buf_addr(buf_addr), .buf_we(buf_we),
      .buf_wdata(buf_wdata), .buf_rdata(buf_rdata), .drive_sel(drive_sel), .head_sel(head_sel),
      .data_req(data_req), .busy(busy), .int_req(int_req));
   disk_side_model partner (.clk(clk), .disk_strobe(disk_strobe), .disk_rd_byte(disk_rd_byte),
      .buf_addr(buf_addr), .buf_we(buf_we), .buf_wdata(buf_wdata), .buf_rdata(buf_rdata));
   task automatic test_done;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic check(input logic [31:0] exp, input logic [31:0] act);
      n_checks++;
      if (act !== exp)
      begin
         n_mismatch++;
         $display("MISMATCH t=%0t exp=%h act=%h", $time, exp, act);
      end
   endtask
   // Bit-serial reference of the check code over the model buffer
   function automatic logic [31:0] ref_crc(input int len);
      logic [31:0] r;
      r = ecc_unit_pkg::crc_init;
      for (int i = 0; i < len; i++)
         for (int j = 7; j >= 0; j--)
            r = {r[30:0], 1'b0} ^ ((r[31] ^ partner.mem[i][j]) ? ecc_unit_pkg::poly : 32'h0000_0000);
      return r;
   endfunction
   task automatic wait_ready;
      logic r;
      for (int k = 0; k < 100; k++)
      begin
         @(negedge clk);
         r = hreadyout;
         rd = hrdata;
         @(posedge clk);
         if (r === 1'b1)
            return;
      end
      n_mismatch++;
      test_done();
   endtask
   task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      wait_ready();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_ready();
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      ahb(a, 1'b0, 32'h0);
      check(exp, rd);
   endtask
   task automatic preset(input logic [15:0] v);
      ahb(ecc_unit_pkg::addr_off, 1'b1, {24'h0, v[7:0]});
      ahb(ecc_unit_pkg::addr_off, 1'b1, {23'h0, 1'b1, v[15:8]});
   endtask
   task automatic run(input logic [31:0] c, input int n, input int gap);
      ahb(ecc_unit_pkg::ctrl_off, 1'b1, c);
      partner.frame(n, gap);
      for (int k = 0; k < 5000; k++)
      begin
         @(negedge clk);
         if (int_req === 1'b1)
         begin
            @(posedge clk);
            return;
         end
      end
      n_mismatch++;
      test_done();
   endtask
   always @(negedge clk)
   begin
      if (disk_wr_valid === 1'b1)
      begin
         cap_q.push_back(disk_wr_byte);
         if (wr_q.size() > 0)
            check({24'h0, wr_q.pop_front()}, {24'h0, disk_wr_byte});
      end
      if (buf_we === 1'b1 && bw_q.size() > 0)
         check({24'h0, bw_q.pop_front()}, {24'h0, buf_wdata});
   end
   initial
   begin
      repeat (3) @(posedge clk);
      reset_n <= 1'b1;
      repeat (3) @(posedge clk);
      rdchk(ecc_unit_pkg::sdh_off, 32'h0);
      ahb(ecc_unit_pkg::sdh_off, 1'b1, 32'h95);
      rdchk(ecc_unit_pkg::sdh_off, 32'h95);
      check(32'h5, {29'h0, head_sel});
      check(32'h2, {29'h0, drive_sel});
      ahb(ecc_unit_pkg::cmd_off, 1'b1, 32'h5a);
      rdchk(ecc_unit_pkg::cmd_off, 32'h5a);
      ahb(8'h40, 1'b1, 32'hff);
      rdchk(8'h40, 32'h0);
      $display("test latches done");
      preset(16'h0234);
      repeat (2) @(posedge clk);
      check(32'h234, {16'h0, buf_addr});
      preset(16'h0);
      for (int i = 0; i < 128; i++)
      begin
         dat[i] = 8'($random(seed));
         bw_q.push_back(dat[i]);
         ahb(ecc_unit_pkg::data_off, 1'b1, {24'h0, dat[i]});
      end
      repeat (2) @(posedge clk);
      check(32'h80, {16'h0, buf_addr});
      $display("test buffer fill done");
      for (int n = 0; n < 4; n++)
      begin
         preset(16'h0);
         cap_q.delete();
         for (int i = 0; i < (128 << n); i++)
            wr_q.push_back(partner.mem[i]);
         s1 = ref_crc(128 << n);
         for (int i = 0; i < 4; i++)
            wr_q.push_back(s1[31-8*i-:8]);
         run(32'h1 | (n << 8), 128 << n, 4);
         check(32'((128 << n) + 4), 32'(cap_q.size()));
         for (int i = 0; i < 4 && n == 0; i++)
            crc[i] = cap_q[128 + i];
         $display("test normal write size %0d done", 128 << n);
      end
      for (int e = 0; e < 2; e++)
      begin
         preset(16'h0200);
         for (int i = 0; i < 132; i++)
         begin
            b = (i < 128) ? dat[i] : crc[i - 128];
            b = (e == 1 && i == 10) ? (b ^ 8'h04) : b;
            partner.rd_q.push_back(b);
            if (i < 128)
               bw_q.push_back(b);
         end
         run(32'h3, 132, 20);
         ahb(ecc_unit_pkg::synd_off, 1'b0, 32'h0);
         s1 = rd;
         check((e == 0) ? 32'h0 : 32'h1, (e == 0) ? s1 : {31'h0, |s1});
         repeat (20) @(posedge clk);
         rdchk(ecc_unit_pkg::synd_off, s1);
         $display("test normal read %0d done", e);
      end
      preset(16'h0);
      b = 8'($random(seed));
      ahb(ecc_unit_pkg::retry_off, 1'b1, {4{b}});
      for (int i = 0; i < 132; i++)
         wr_q.push_back((i < 128) ? dat[i] : b);
      run(32'h5, 128, 4);
      $display("test raw trailer write done");
      preset(16'h0300);
      for (int i = 0; i < 132; i++)
      begin
         b = 8'($random(seed));
         partner.rd_q.push_back(b);
         bw_q.push_back(b);
      end
      run(32'h7, 132, 4);
      check(32'h0, 32'(wr_q.size() + bw_q.size()));
      $display("test raw trailer read done");
      test_done();
   end
endmodule // tb_disk_sector_ecc_and_buffer_control
